// ==== design/rf_config_ctrl_commands.sv ====
// custom rf command interpreter: pin config write, harvest enable set, harvest control read
// Functional notes
// - command A4h programs the request data byte into the configuration byte
// - configuration write ignores data bits 2..0, keeping those bits
// - protocol extension flag set gives an error response, no execution
// - write success answers flags and CRC only, after write cycle completes
// - failed programming answers error flag and code 13h
// - busy mode: pin low from request start of frame to response end
// - write-progress mode: pin low from valid request end until the write cycle completes
// - write-progress mode: pin high impedance for set and read commands
// - command A2h sets or clears harvest enable bit in control register
// - harvest enable value taken from data bit 0, bits 7..1 ignored
// - harvest set success answers flags and CRC after standard delay; the design raises RSP_VALID_OUT the cycle after the request
// - unsupported option on set or read commands gives error 03h
// - command A3h returns the 8-bit control register after response flags
// - request carries flags, code, maker code, optional id, data, CRC
// - error response is flags with error bit, error code, CRC
`timescale 1ns/1ns
`default_nettype none

module rf_config_ctrl_commands
  import rf_cfg_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h00_5A, // arbitrary value
  parameter int NOMINAL_DELAY_CYCLES = 32'd32,
  parameter int WRITE_CYCLES = NOMINAL_DELAY_CYCLES + WRITE_EXTRA_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  // decoded request from the rf front end
  input wire logic REQ_SOF_IN,
  input wire logic REQ_VALID_IN,
  input wire rf_req_t REQ_IN,
  // response handshake to the rf front end
  output logic RSP_VALID_OUT,
  output rf_rsp_t RSP_OUT,
  input wire logic RSP_START_IN,
  input wire logic RSP_DONE_IN,
  // nonvolatile programming port
  output logic NV_WRITE_OUT,
  output logic [7:0] NV_DATA_OUT,
  input wire logic NV_FAIL_IN,
  // state
  output logic [7:0] CONFIG_OUT,
  output logic HARVEST_EN_OUT,
  // status pin (open drain style)
  output logic STATUS_PIN_OUT,
  output logic STATUS_PIN_OE_OUT
);

  typedef enum logic [2:0] {S_IDLE, S_FRAME, S_WRITE, S_WAIT_START, S_SENDING} st_t;

  st_t st_r, st_nxt;
  logic [7:0] cfg_r;
  logic [7:0] ctrl_r;
  logic [31:0] cnt_r;
  logic oe_r;
  logic rsp_valid_r;
  rf_rsp_t rsp_r;
  logic nv_wr_r;

  // ==========================================================
  // request decode
  wire accept = REQ_IN.crc_ok && (REQ_IN.maker == MAKER_CODE);
  wire is_wr = REQ_IN.cmd == CMD_WRITE_PIN_CFG;
  wire is_set = REQ_IN.cmd == CMD_SET_HARVEST;
  wire is_rd = REQ_IN.cmd == CMD_READ_HARVEST;
  wire is_ours = is_wr || is_set || is_rd;
  wire prot_ext = REQ_IN.flags[FLAG_PROT_EXT];
  wire bad_opt = (is_set && (REQ_IN.flags[FLAG_OPTION] || REQ_IN.flags[FLAG_INVENTORY]))
    || (is_rd && (REQ_IN.flags[FLAG_OPTION] || REQ_IN.flags[FLAG_INVENTORY]));
  wire take = CLK_EN_IN && REQ_VALID_IN && accept && is_ours && st_r == S_FRAME;
  wire run_write = take && is_wr && !prot_ext;
  wire run_set = take && is_set && !prot_ext && !bad_opt;
  wire write_done = st_r == S_WRITE && cnt_r == 32'd0;
  wire busy_mode = !cfg_r[CFG_PIN_MODE_BIT];
  wire [7:0] cfg_new = (cfg_r & ~CFG_WRITE_MASK) | (REQ_IN.data & CFG_WRITE_MASK);

  function automatic rf_rsp_t err_rsp(input logic [7:0] code);
    err_rsp = '{flags: RSP_FLAGS_ERR, payload: code, has_payload: 1'b1};
  endfunction

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (REQ_SOF_IN) st_nxt = S_FRAME;
      S_FRAME: begin
        if (REQ_VALID_IN) begin
          if (!accept || !is_ours) st_nxt = S_IDLE;
          else if (run_write) st_nxt = S_WRITE;
          else st_nxt = S_WAIT_START;
        end
      end
      S_WRITE: if (write_done) st_nxt = S_WAIT_START;
      S_WAIT_START: if (RSP_START_IN) st_nxt = S_SENDING;
      S_SENDING: if (RSP_DONE_IN) st_nxt = S_IDLE;
    endcase
  end

  // ==========================================================
  // state, counter and registers
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= S_IDLE;
      cnt_r <= 32'd0;
    end else if (CLK_EN_IN) begin
      st_r <= st_nxt;
      if (run_write) cnt_r <= 32'(WRITE_CYCLES - 1);
      else if (cnt_r != 32'd0) cnt_r <= cnt_r - 32'd1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg_r <= CFG_RESET;
      ctrl_r <= CTRL_RESET;
      nv_wr_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      nv_wr_r <= run_write;
      if (write_done && !NV_FAIL_IN) cfg_r <= NV_DATA_OUT;
      if (run_set) ctrl_r[CTRL_HARVEST_BIT] <= REQ_IN.data[0];
    end
  end

  logic [7:0] nv_data_r;
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) nv_data_r <= CFG_RESET;
    else if (CLK_EN_IN && run_write) nv_data_r <= cfg_new;
  end

  // ==========================================================
  // response building
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else if (CLK_EN_IN) begin
      if (take && !run_write) begin
        rsp_valid_r <= 1'b1;
        if (prot_ext || bad_opt) rsp_r <= err_rsp(ERR_OPTION);
        else if (is_rd) rsp_r <= '{flags: RSP_FLAGS_OK, payload: ctrl_r,
                                   has_payload: 1'b1};
        else rsp_r <= '{flags: RSP_FLAGS_OK, payload: 8'h00_00, has_payload: 1'b0};
      end else if (write_done) begin
        rsp_valid_r <= 1'b1;
        if (NV_FAIL_IN) rsp_r <= err_rsp(ERR_PROGRAM);
        else rsp_r <= '{flags: RSP_FLAGS_OK, payload: 8'h00_00, has_payload: 1'b0};
      end else if (RSP_START_IN) begin
        rsp_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status pin: driven low when active, released otherwise
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      oe_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (busy_mode) oe_r <= st_nxt != S_IDLE;
      else oe_r <= st_nxt == S_WRITE;
    end
  end

  assign RSP_VALID_OUT = rsp_valid_r;
  assign RSP_OUT = rsp_r;
  assign NV_WRITE_OUT = nv_wr_r;
  assign NV_DATA_OUT = nv_data_r;
  assign CONFIG_OUT = cfg_r;
  assign HARVEST_EN_OUT = ctrl_r[CTRL_HARVEST_BIT];
  assign STATUS_PIN_OUT = 1'b0;
  assign STATUS_PIN_OE_OUT = oe_r;

endmodule

`default_nettype wire

// ==== design/rf_cfg_pkg.sv ====
// package for the rf configuration and harvest control command interpreter
package rf_cfg_pkg;

  // ==========================================================
  // command codes and fields
  localparam logic [7:0] CMD_WRITE_PIN_CFG = 8'h00_A4;
  localparam logic [7:0] CMD_SET_HARVEST = 8'h00_A2;
  localparam logic [7:0] CMD_READ_HARVEST = 8'h00_A3;
  localparam logic [7:0] ERR_OPTION = 8'h00_03;
  localparam logic [7:0] ERR_PROGRAM = 8'h00_13;
  localparam logic [7:0] RSP_FLAGS_OK = 8'h00_00;
  localparam logic [7:0] RSP_FLAGS_ERR = 8'h00_01;
  // request flag bit positions
  localparam int FLAG_PROT_EXT = 3;
  localparam int FLAG_INVENTORY = 2;
  localparam int FLAG_OPTION = 6;
  // configuration byte bits taken from request data on a write (7..3)
  localparam logic [7:0] CFG_WRITE_MASK = 8'h00_F8;
  localparam int CFG_PIN_MODE_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'h00_00;
  localparam logic [7:0] CTRL_RESET = 8'h00_00;
  localparam int CTRL_HARVEST_BIT = 0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_PERIOD_US = 302;
  localparam int WRITE_PERIODS = 18;
  localparam int WRITE_EXTRA_CYCLES =
    WRITE_PERIODS * WRITE_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] cmd;
    logic [7:0] maker;
    logic [7:0] data;
    logic crc_ok;
  } rf_req_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] payload;
    logic has_payload;
  } rf_rsp_t;

endpackage

// ==== tb/rf_config_ctrl_commands_chk.sv ====
// port assertions for the rf command interpreter
`timescale 1ns/1ns
`default_nettype none
module rf_config_ctrl_commands_chk
  import rf_cfg_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h00_5A
) (
  input wire logic CLK_SYS_IN, RST_N_IN, CLK_EN_IN, REQ_SOF_IN, REQ_VALID_IN,
  input wire rf_req_t REQ_IN,
  input wire logic RSP_VALID_OUT,
  input wire rf_rsp_t RSP_OUT,
  input wire logic RSP_START_IN, RSP_DONE_IN, NV_WRITE_OUT, NV_FAIL_IN,
  input wire logic [7:0] NV_DATA_OUT,
  input wire logic [7:0] CONFIG_OUT,
  input wire logic HARVEST_EN_OUT, STATUS_PIN_OUT, STATUS_PIN_OE_OUT
);
  // ==========
  // properties
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  wire logic set_ok = REQ_VALID_IN && CLK_EN_IN && REQ_IN.crc_ok && REQ_IN.maker == MAKER_CODE
    && REQ_IN.cmd == CMD_SET_HARVEST && (REQ_IN.flags & 8'h00_4C) == 8'h00_00;
  wire logic wip = CONFIG_OUT[CFG_PIN_MODE_BIT];
  a_set_fast_rsp: assert property (set_ok |=> RSP_VALID_OUT && HARVEST_EN_OUT == $past(REQ_IN.data[0])) else $error("harvest set answer wrong");
  a_err_form: assert property (RSP_VALID_OUT && RSP_OUT.flags == RSP_FLAGS_ERR |-> RSP_OUT.has_payload
    && (RSP_OUT.payload == ERR_OPTION || RSP_OUT.payload == ERR_PROGRAM)) else $error("bad error answer");
  a_read_value: assert property (RSP_VALID_OUT && RSP_OUT.flags == RSP_FLAGS_OK && RSP_OUT.has_payload
    |-> RSP_OUT.payload == {7'h00, HARVEST_EN_OUT}) else $error("read value wrong");
  a_cfg_low_kept: assert property ($changed(CONFIG_OUT) |-> CONFIG_OUT[2:0] == $past(CONFIG_OUT[2:0])) else $error("low config bits changed");
  a_cfg_then_rsp: assert property ($changed(CONFIG_OUT) |-> ##[0:1] RSP_VALID_OUT) else $error("config changed without answer");
  a_write_wait: assert property ($rose(NV_WRITE_OUT) |-> (!RSP_VALID_OUT)[*8]) else $error("answer before write done");
  a_nv_keep_low: assert property (NV_WRITE_OUT |-> NV_DATA_OUT[2:0] == CONFIG_OUT[2:0]) else $error("write data low bits");
  a_busy_held: assert property (RSP_VALID_OUT && !wip && $stable(CONFIG_OUT) |-> STATUS_PIN_OE_OUT) else $error("busy pin released");
  a_wip_quiet: assert property (RSP_VALID_OUT && wip && $stable(CONFIG_OUT) |-> !STATUS_PIN_OE_OUT) else $error("wip pin driven");
  a_pin_low: assert property (STATUS_PIN_OE_OUT |-> !STATUS_PIN_OUT) else $error("pin driven high");
  a_silent_bad: assert property (REQ_VALID_IN && !REQ_IN.crc_ok |=> (!RSP_VALID_OUT && !NV_WRITE_OUT)[*3]) else $error("bad crc acted on");
  cover property (set_ok);
  cover property ($rose(NV_WRITE_OUT));
  cover property (RSP_VALID_OUT && wip);
endmodule
bind rf_config_ctrl_commands rf_config_ctrl_commands_chk #(.MAKER_CODE(MAKER_CODE)) i_chk (.*);
`default_nettype wire

// ==== tb/rf_reader_model.sv ====
// reader side model: starts and ends the tag response frame
`timescale 1ns/1ns
`default_nettype none
module rf_reader_model (
  input wire logic clk_in,
  input wire logic rsp_valid_in,
  input wire logic [3:0] gap_in,
  output logic start_out,
  output logic done_out
);
  // ==========
  // response frame timing, prompt or slow by gap
  initial begin
    start_out = 1'b0;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (rsp_valid_in) begin
        repeat (gap_in) @(posedge clk_in);
        @(negedge clk_in) start_out = 1'b1;
        @(negedge clk_in) start_out = 1'b0;
        repeat (gap_in + 2) @(negedge clk_in);
        done_out = 1'b1;
        @(negedge clk_in) done_out = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/rf_config_ctrl_commands_tb.sv ====
// self-checking bench for the rf command interpreter
`timescale 1ns/1ns
`default_nettype none
module rf_config_ctrl_commands_tb;
  import rf_cfg_pkg::*;
  localparam logic [7:0] MK = 8'h00_5A; // arbitrary maker value
  logic clk = 1'b0, rst_n = 1'b0, sof = 1'b0, vld = 1'b0, nv_fail = 1'b0, seen = 1'b0;
  logic clk_en = 1'b1;
  logic start, done, rv, nvw, oe, pin, hv, hv_m = 1'b0;
  logic [7:0] cfg, nvd, cfg_m = 8'h00_00;
  logic [3:0] gap = 4'h0;
  logic [31:0] r;
  rf_req_t req = '0;
  rf_rsp_t rsp, e;
  rf_rsp_t exp_q[$];
  int err_total = 0, checks_done = 0, seed = 90;
  logic [7:0] cmds [4] = '{CMD_WRITE_PIN_CFG, CMD_SET_HARVEST, CMD_READ_HARVEST, 8'h00_A0};
  logic [7:0] fls [4] = '{8'h00_00, 8'h00_08, 8'h00_40, 8'h00_04};
  always #5 clk = ~clk;
  rf_config_ctrl_commands #(.MAKER_CODE(MK), .WRITE_CYCLES(50)) i_dut (.CLK_SYS_IN(clk),
    .RST_N_IN(rst_n), .CLK_EN_IN(clk_en), .REQ_SOF_IN(sof), .REQ_VALID_IN(vld), .REQ_IN(req),
    .RSP_VALID_OUT(rv), .RSP_OUT(rsp), .RSP_START_IN(start), .RSP_DONE_IN(done),
    .NV_WRITE_OUT(nvw), .NV_DATA_OUT(nvd), .NV_FAIL_IN(nv_fail), .CONFIG_OUT(cfg),
    .HARVEST_EN_OUT(hv), .STATUS_PIN_OUT(pin), .STATUS_PIN_OE_OUT(oe));
  rf_reader_model i_rdr (.clk_in(clk), .rsp_valid_in(rv), .gap_in(gap), .start_out(start),
    .done_out(done));
  // ==========
  // checking
  task automatic check(string nm, logic [16:0] x, logic [16:0] g);
    checks_done++;
    if (x !== g) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  always @(negedge clk) begin
    if (rv && !seen) begin
      e = exp_q.size() ? exp_q.pop_front() : rf_rsp_t'{8'h00_FF, 8'h00_FF, 1'b1};
      check("rsp", {e.flags, e.payload, e.has_payload}, {rsp.flags,
        rsp.has_payload ? rsp.payload : 8'h00_00, rsp.has_payload});
    end
    seen = rv;
  end
  task automatic send(logic [7:0] fl, logic [7:0] cmd, logic [7:0] mk, logic [7:0] d, logic ok);
    logic good;
    rf_rsp_t x;
    good = ok && mk == MK && cmd != 8'h00_A0;
    x = '{RSP_FLAGS_ERR, ERR_OPTION, 1'b1};
    if (fl[FLAG_PROT_EXT] || (cmd != CMD_WRITE_PIN_CFG && fl != 8'h00_00) || !good) begin
    end else if (cmd == CMD_WRITE_PIN_CFG) begin
      x = nv_fail ? rf_rsp_t'{RSP_FLAGS_ERR, ERR_PROGRAM, 1'b1} :
        rf_rsp_t'{RSP_FLAGS_OK, 8'h00_00, 1'b0};
      if (!nv_fail) cfg_m = (cfg_m & ~CFG_WRITE_MASK) | (d & CFG_WRITE_MASK);
    end else if (cmd == CMD_SET_HARVEST) begin
      x = '{RSP_FLAGS_OK, 8'h00_00, 1'b0};
      hv_m = d[0];
    end else x = '{RSP_FLAGS_OK, {7'h00, hv_m}, 1'b1};
    if (good) exp_q.push_back(x);
    @(negedge clk) sof = 1'b1;
    @(negedge clk) sof = 1'b0;
    @(negedge clk) req = '{fl, cmd, mk, d, ok};
    vld = 1'b1;
    @(negedge clk) vld = 1'b0;
    if (good) begin
      repeat (400) if (!done) @(posedge clk);
      if (!done) check("done", 17'h1, 17'h0);
      repeat (2) @(negedge clk);
    end else repeat (8) @(negedge clk);
    check("config", {9'h0, cfg_m}, {9'h0, cfg});
    check("harvest", {16'h0, hv_m}, {16'h0, hv});
  endtask
  task automatic close_out();
    if (exp_q.size() != 0) begin
      err_total++;
      $display("mismatch pending exp %0d got %0d", 0, exp_q.size());
    end
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      nv_fail = r[13:12] == 2'b00;
      gap = r[17:14];
      // freeze the idle block for a cycle now and then
      @(negedge clk) clk_en = r[20];
      @(negedge clk) clk_en = 1'b1;
      send(fls[r[3:2]] & (r[1:0] == 2'd0 ? 8'h00_08 : 8'h00_FF), cmds[r[1:0]],
        r[7:4] == 4'h0 ? ~MK : MK, r[31:24], r[11:8] != 4'h0);
    end
    close_out();
  end
  initial begin
    #200_000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
